// File: dv/cap_attach_gate_tb_top.sv
// bench top: random plug, polarity and mode, queued expectations
// assumes the design settles within four edges of a pin change
`default_nettype none
module cap_attach_gate_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst_n = 0, plugIn = 0, flip = 0, pol = 1, modeSel = 0, extSel = 0;
  logic [2:0] attachInd, activeCfg;
  logic [1:0] ssPhyEn;
  logic       orient, laneA, laneB, ssClkEn, attached, orientationFlip, f;
  logic [7:0] obs;
  logic [7:0] expQ[$];
  int         num_errors = 0, checked = 0;
  event       seen;
  always #10 core_clk = ~core_clk;
  cap_ctrl_model u_ctrl (.plugIn(plugIn), .flip(flip), .pol(pol), .attachInd(attachInd),
    .orient(orient), .laneA(laneA), .laneB(laneB));
  cap_attach_gate u_dut (.core_clk(core_clk), .rst_n(rst_n), .attach_ind(attachInd),
    .plug_orientation_in(orient), .mux_attach_lane_a(laneA), .mux_attach_lane_b(laneB),
    .attach_polarity_sel(pol), .internal_mux_mode_sel(modeSel), .external_mux_sel(extSel),
    .ssClkEn(ssClkEn), .ssPhyEn(ssPhyEn), .attached(attached),
    .orientationFlip(orientationFlip), .activeCfg(activeCfg));
  assign obs = {ssClkEn, ssPhyEn, attached, orientationFlip, activeCfg};
  task automatic cmp(input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] outputs exp %h got %h", e, s);
    end
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    void'($urandom(14596));
    repeat (2) @(posedge core_clk);
    #2 rst_n = 1;
    for (int i = 0; i < 80; i++)
    begin
      @(posedge core_clk);
      #2 {plugIn, flip, pol, modeSel, extSel} = 5'($urandom);
      // long hold so the checker's settle window and sync check both get reached
      repeat (8) @(posedge core_clk);
      // external mux never reports a flipped plug
      f = ~extSel & plugIn & flip;
      expQ.push_back({plugIn, f, plugIn & ~f, plugIn, f,
                      extSel ? 3'h1 : (modeSel ? 3'h4 : 3'h2)});
      -> seen;
    end
    // let the last queued compare run before the verdict
    @(posedge core_clk);
    tally_and_finish();
  end
  always @(seen)
    #1 cmp(expQ.pop_front(), obs);
endmodule // cap_attach_gate_tb_top
bind cap_attach_gate cap_gate_assertions u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .attach_ind(attach_ind), .plug_orientation_in(plug_orientation_in),
  .mux_attach_lane_a(mux_attach_lane_a), .mux_attach_lane_b(mux_attach_lane_b),
  .attach_polarity_sel(attach_polarity_sel), .internal_mux_mode_sel(internal_mux_mode_sel),
  .external_mux_sel(external_mux_sel), .ssClkEn(ssClkEn), .ssPhyEn(ssPhyEn),
  .attached(attached), .orientationFlip(orientationFlip), .activeCfg(activeCfg));
`default_nettype wire

// File: dv/cap_ctrl_model.sv
// outside connector controller: drives attach pins at the chosen polarity
// assumes plug state is set by the bench
`default_nettype none
module cap_ctrl_model (
  input  wire logic       plugIn,
  input  wire logic       flip,
  input  wire logic       pol,
  output logic      [2:0] attachInd,
  output logic            orient,
  output logic            laneA,
  output logic            laneB
);
  assign attachInd = {3{plugIn ~^ pol}};
  assign orient = flip ~^ pol;
  assign laneA = (plugIn & ~flip) ~^ pol;
  assign laneB = (plugIn & flip) ~^ pol;
endmodule // cap_ctrl_model
`default_nettype wire

// File: dv/cap_gate_assertions.sv
// port checker for the attach front end
// assumes a bind from the bench top file
`default_nettype none
module cap_gate_assertions (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [2:0] attach_ind,
  input wire logic       plug_orientation_in,
  input wire logic       mux_attach_lane_a,
  input wire logic       mux_attach_lane_b,
  input wire logic       attach_polarity_sel,
  input wire logic       internal_mux_mode_sel,
  input wire logic       external_mux_sel,
  input wire logic       ssClkEn,
  input wire logic [1:0] ssPhyEn,
  input wire logic       attached,
  input wire logic       orientationFlip,
  input wire logic [2:0] activeCfg
);
  logic [8:0] pins;
  logic [5:0] act;
  logic [2:0] stab;
  logic [2:0] eC;
  logic       eA;
  logic       eF;
  assign pins = {attach_ind, plug_orientation_in, mux_attach_lane_a, mux_attach_lane_b,
                 attach_polarity_sel, internal_mux_mode_sel, external_mux_sel};
  assign act = pins[8:3] ^ {6{~attach_polarity_sel}};
  assign eC = external_mux_sel ? 3'h1 : (internal_mux_mode_sel ? 3'h4 : 3'h2);
  assign eA = eC[0] ? |act[5:3] : (eC[1] ? act[3] : act[1] | act[0]);
  assign eF = eC[1] ? act[3] & act[2] : eC[2] & act[0] & ~act[1];
  // settle counter; conservative so sync latency never trips a check
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) stab <= 3'h0;
    else if ($changed(pins)) stab <= 3'h0;
    else if (stab != 3'h7) stab <= stab + 3'h1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // stab lags the current sample by one edge, so a fresh change must be excluded too
  sequence s_settled;
    stab > 3'h3 && $stable(pins);
  endsequence
  sequence s_calm_then_move;
    stab == 3'h7 ##1 $changed(pins);
  endsequence
  a_clk_follow: assert property (ssClkEn == attached)
    else $error("clock enable differs from attach");
  a_cfg_value: assert property (s_settled |-> activeCfg == eC)
    else $error("wrong config");
  a_attach_value: assert property (s_settled |-> attached == eA)
    else $error("wrong attach");
  a_flip_value: assert property (s_settled |-> orientationFlip == eF)
    else $error("wrong orientation");
  a_phy_value: assert property (s_settled |-> ssPhyEn == {eF, eA & ~eF})
    else $error("wrong phy enables");
  a_phy_single: assert property ($onehot0(ssPhyEn))
    else $error("both phys enabled");
  a_ext_lane: assert property (activeCfg == 3'h1 |-> !ssPhyEn[1])
    else $error("flipped phy in external mode");
  a_sync_hold: assert property (s_calm_then_move |-> $stable(ssPhyEn) ##1 $stable(attached))
    else $error("outputs moved before sync");
endmodule // cap_gate_assertions
`default_nettype wire

// File: hw/cap_attach_gate.sv
// attach and orientation front end gating superspeed phy clocking and lanes
// assumes an outside connector controller drives the attach pins; all pins asynchronous
`default_nettype none

module cap_attach_gate (
  input  wire logic      core_clk,
  input  wire logic      rst_n,
  input  wire logic [2:0] attach_ind,
  input  wire logic      plug_orientation_in,
  input  wire logic      mux_attach_lane_a,
  input  wire logic      mux_attach_lane_b,
  input  wire logic      attach_polarity_sel,
  input  wire logic      internal_mux_mode_sel,
  input  wire logic      external_mux_sel,
  output logic           ssClkEn,
  output logic [1:0]     ssPhyEn,
  output logic           attached,
  output logic           orientationFlip,
  output logic [2:0]     activeCfg
);

  cap_pkg::cap_pins_t rawPins;
  cap_pkg::cap_pins_t syncPins;
  cap_pkg::cap_pins_t livePins;
  logic [2:0]         syncCtl;
  logic               polHigh;
  logic               modeSelHigh;
  logic               extMux;
  cap_pkg::cap_cfg_t  cfg;
  logic               extAttached;
  cap_pkg::cap_phy_t  extPhy;
  logic               m1Attached;
  logic               m1Flip;
  cap_pkg::cap_phy_t  m1Phy;
  logic               m2Attached;
  logic               m2Flip;
  cap_pkg::cap_phy_t  m2Phy;
  cap_pkg::cap_phy_t  next_phy;
  logic               next_attached;
  logic               next_orientationFlip;
  logic [2:0]         next_activeCfg;

  always_comb
  begin
    rawPins.attachInd         = attach_ind;
    rawPins.plugOrientationIn = plug_orientation_in;
    rawPins.muxAttachLaneA    = mux_attach_lane_a;
    rawPins.muxAttachLaneB    = mux_attach_lane_b;
  end

  cap_sync #(
    .WIDTH (cap_pkg::PIN_WIDTH)
  ) u_pinSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .asyncIn  (rawPins),
    .syncOut  (syncPins)
  );

  // straps synchronised too; they may be wired to slow pull resistors
  cap_sync #(
    .WIDTH (3)
  ) u_ctlSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .asyncIn  ({attach_polarity_sel, internal_mux_mode_sel, external_mux_sel}),
    .syncOut  (syncCtl)
  );

  // strap bits in the order they were packed for the synchroniser
  always_comb
  begin
    polHigh     = syncCtl[2];
    modeSelHigh = syncCtl[1];
    extMux      = syncCtl[0];
  end

  // normalised to active high once, so no decoder below sees polarity
  always_comb
  begin
    if (polHigh)
    begin
      livePins = syncPins;
    end
    else
    begin
      livePins = cap_pkg::cap_pins_t'(~syncPins);
    end
  end

  // external mux wins; floating mode select reads low, so mode 1 by default
  always_comb
  begin
    if (extMux)
    begin
      cfg = cap_pkg::CAP_CFG_EXT_MUX;
    end
    else if (modeSelHigh)
    begin
      cfg = cap_pkg::CAP_CFG_MODE2;
    end
    else
    begin
      cfg = cap_pkg::CAP_CFG_MODE1;
    end
  end

  // external mux routes lanes itself, so one phy follows the clock gate
  always_comb
  begin
    extAttached    = |livePins.attachInd;
    extPhy.ssClkEn = extAttached;
    extPhy.ssPhyEn = {1'h0, extAttached};
  end

  // mode 1: orientation only counts while attach input 0 is active
  always_comb
  begin
    m1Attached    = livePins.attachInd[0];
    m1Flip        = livePins.attachInd[0] & livePins.plugOrientationIn;
    m1Phy.ssClkEn = m1Attached;
    m1Phy.ssPhyEn = {m1Attached & m1Flip,
                     m1Attached & ~m1Flip};
  end

  // mode 2: both lanes at once is ambiguous; lane a is preferred
  always_comb
  begin
    m2Attached    = livePins.muxAttachLaneA | livePins.muxAttachLaneB;
    m2Flip        = livePins.muxAttachLaneB & ~livePins.muxAttachLaneA;
    m2Phy.ssClkEn = m2Attached;
    m2Phy.ssPhyEn = {m2Flip, livePins.muxAttachLaneA};
  end

  // only the decoder of the active configuration reaches the phy flops
  always_comb
  begin
    next_phy = '0;
    case (cfg)
      cap_pkg::CAP_CFG_EXT_MUX:
      begin
        next_phy = extPhy;
      end
      cap_pkg::CAP_CFG_MODE1:
      begin
        next_phy = m1Phy;
      end
      cap_pkg::CAP_CFG_MODE2:
      begin
        next_phy = m2Phy;
      end
      default:
      begin
        next_phy = '0;
      end
    endcase
  end

  // status uses the same selection; external mux has no orientation to report
  always_comb
  begin
    next_attached        = 1'h0;
    next_orientationFlip = 1'h0;
    case (cfg)
      cap_pkg::CAP_CFG_EXT_MUX:
      begin
        next_attached = extAttached;
      end
      cap_pkg::CAP_CFG_MODE1:
      begin
        next_attached        = m1Attached;
        next_orientationFlip = m1Flip;
      end
      cap_pkg::CAP_CFG_MODE2:
      begin
        next_attached        = m2Attached;
        next_orientationFlip = m2Flip;
      end
      default:
      begin
        next_attached = 1'h0;
      end
    endcase
    next_activeCfg = cfg;
  end

  // phy gating flops; reset leaves every superspeed phy off
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ssClkEn <= cap_pkg::CLK_EN_RST;
      ssPhyEn <= cap_pkg::PHY_EN_RST;
    end
    else
    begin
      ssClkEn <= next_phy.ssClkEn;
      ssPhyEn <= next_phy.ssPhyEn;
    end
  end

  // status flops for whatever reports the connector state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      attached        <= cap_pkg::ATTACHED_RST;
      orientationFlip <= cap_pkg::FLIP_RST;
      activeCfg       <= cap_pkg::CFG_RST;
    end
    else
    begin
      attached        <= next_attached;
      orientationFlip <= next_orientationFlip;
      activeCfg       <= next_activeCfg;
    end
  end

endmodule // cap_attach_gate

`default_nettype wire

// File: hw/cap_pkg.sv
// package for the connector attach front end: config modes, carriers, reset values
// assumes one core clock domain and an active-low asynchronous chip reset
`default_nettype none

package cap_pkg;

  localparam int unsigned SYNC_STAGES   = 2;
  localparam int unsigned ATTACH_WIDTH  = 3;
  localparam logic        SYNC_RST_VAL  = 1'h0;
  localparam logic [1:0]  PHY_EN_RST    = 2'h0;
  localparam logic        CLK_EN_RST    = 1'h0;
  localparam logic        ATTACHED_RST  = 1'h0;
  localparam logic        FLIP_RST      = 1'h0;
  localparam logic [2:0]  CFG_RST       = 3'h0;

  // three connector configurations, one-hot
  typedef enum logic [2:0] {
    CAP_CFG_EXT_MUX = 3'h1,
    CAP_CFG_MODE1   = 3'h2,
    CAP_CFG_MODE2   = 3'h4
  } cap_cfg_t;

  // raw connector controller inputs
  typedef struct packed {
    logic [2:0] attachInd;
    logic       plugOrientationIn;
    logic       muxAttachLaneA;
    logic       muxAttachLaneB;
  } cap_pins_t;

  // phy gating outputs
  typedef struct packed {
    logic       ssClkEn;
    logic [1:0] ssPhyEn;
  } cap_phy_t;

  localparam int unsigned PIN_WIDTH = $bits(cap_pins_t);

endpackage : cap_pkg

`default_nettype wire

// File: hw/cap_sync.sv
// two-flop synchroniser, parameterised width
// assumes inputs may change at any time relative to core_clk
`default_nettype none

module cap_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_syncOut;

  // first stage feeds only the second
  always_comb
  begin
    next_stage1  = asyncIn;
    next_syncOut = stage1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1  <= {WIDTH{cap_pkg::SYNC_RST_VAL}};
      syncOut <= {WIDTH{cap_pkg::SYNC_RST_VAL}};
    end
    else
    begin
      stage1  <= next_stage1;
      syncOut <= next_syncOut;
    end
  end

endmodule // cap_sync

`default_nettype wire
